// file: hw/mtcmp_pkg.sv
// Shared constants, types and state layout of the threshold comparator.
`default_nettype none

package mtcmp_pkg;

	// Data path sizes
	localparam int DATA_W = 32; // Measured value and threshold width
	localparam int SET_N = 16; // Number of comparison sets
	localparam int SET_W = 4; // Set index width
	localparam int LVL_N = 4; // Thresholds per set
	localparam int LVL_W = 2; // Threshold index width
	localparam int NLEV_W = 3; // Holds a level count of 0 to 4
	localparam int BAND_N = 5; // Judgment outputs
	localparam int BAND_W = 3; // Band index width
	localparam int ADDR_W = 7; // Avalon word address width
	localparam int BE_W = 4; // Byte enables
	localparam int IN_N = 5; // Four select pins plus the latch pin
	localparam int IN_LATCH_BIT = 4; // Latch pin position in the input vector
	localparam int CNT_W = 16; // Input filter counter width

	// Timing, in microseconds as specified, then in clock cycles
	localparam longint CLK_HZ = 10_000_000;
	localparam longint US_PER_S = 1_000_000;
	localparam int INT_DELAY_US = 3000; // Least time to internal operation
	localparam int DEB_DELAY_US = 350; // Turn-on delay with debounce option
	localparam int FAST_DELAY_US = 3; // Turn-on delay without debounce

	// Least times round up to whole cycles, never below one
	function automatic int mtcmp_us_to_cyc(input int us);
		longint c;
		c = (longint'(us) * CLK_HZ + US_PER_S - 1) / US_PER_S;
		return (c < 1) ? 1 : int'(c);
	endfunction : mtcmp_us_to_cyc

	localparam int INT_DELAY_CYC = mtcmp_us_to_cyc(INT_DELAY_US);
	localparam int DEB_DELAY_CYC = mtcmp_us_to_cyc(DEB_DELAY_US);
	localparam int FAST_DELAY_CYC = mtcmp_us_to_cyc(FAST_DELAY_US);

	// Register map, word addresses
	localparam logic [ADDR_W-1:0] ADR_THR_LAST = 7'h3F; // Thresholds 00..3F
	localparam logic [ADDR_W-1:0] ADR_CTRL = 7'h40;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 7'h41;
	localparam logic [ADDR_W-1:0] ADR_MEAS = 7'h42;
	localparam int ADR_LVL_LSB = 0; // Threshold index inside a set
	localparam int ADR_SET_LSB = 2; // Set number field of the address

	// Control register fields
	localparam int CTRL_MODE_BIT = 0; // 1 = positioning, 0 = comparator
	localparam int CTRL_DEB_BIT = 1; // Debounce option connected
	localparam int CTRL_SWSEL_BIT = 2; // Software chooses the set
	localparam int CTRL_SWSET_LSB = 4; // Software set number
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int ST_JUDGE_LSB = 0;
	localparam int ST_SET_LSB = 8;
	localparam int ST_LATCH_BIT = 12;
	localparam int ST_REJ_BIT = 13;
	localparam int ST_NLEV_LSB = 16;

	// Reset values
	localparam logic [IN_N-1:0] IN_IDLE = 5'h1F; // Undriven pins read high
	localparam logic [BAND_N-1:0] JUDGE_RESET = 5'h01; // Band 0 only
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	// Types
	typedef logic [DATA_W-1:0] mtcmp_word_t;
	typedef mtcmp_word_t [LVL_N-1:0] mtcmp_set_t;

	typedef enum logic [1:0] {
		MTCMP_IDLE = 2'b00,
		MTCMP_EVAL = 2'b01,
		MTCMP_ACK = 2'b10
	} mtcmp_bus_e;

	// One write into the threshold memory
	typedef struct packed {
		logic we;
		logic [SET_W-1:0] addr;
		mtcmp_set_t data;
	} mtcmp_memwr_s;

	// One Avalon request as the master holds it
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		mtcmp_word_t wdata;
		logic [BE_W-1:0] be;
	} mtcmp_avs_req_s;

	// Whole state of the comparator top
	typedef struct packed {
		logic [IN_N-1:0] sync1;
		logic [IN_N-1:0] sync2;
		logic [IN_N-1:0] samp;
		logic [CNT_W-1:0] cnt;
		logic [IN_N-1:0] acc;
		logic mode_pos;
		logic deb_on;
		logic sw_sel;
		logic [SET_W-1:0] sw_set;
		logic [SET_N-1:0][NLEV_W-1:0] nlev;
		mtcmp_bus_e bstate;
		logic waitreq;
		mtcmp_word_t rdata;
		logic wr_rej;
		logic rd_judge;
		logic [SET_W-1:0] rd_set;
		logic latched;
		logic [BAND_N-1:0] judge;
	} mtcmp_state_s;

endpackage : mtcmp_pkg

`default_nettype wire

// file: hw/mtcmp_thr_mem.sv
// Threshold store: sixteen sets of four words, registered read port.
`default_nettype none

module mtcmp_thr_mem
	import mtcmp_pkg::*;
(
	// Clock, reset and freeze
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CE,
	// Write port
	input var mtcmp_memwr_s WR,
	// Read port, data one cycle after the address
	input wire logic [SET_W-1:0] RADDR,
	output logic [LVL_N*DATA_W-1:0] RDATA
);

	mtcmp_set_t mem [SET_N]; // One word holds a full set
	mtcmp_set_t rdata_q; // Registered read data

	// Array is not reset, so it stays a plain RAM; counts guard it
	always_ff @(posedge CLOCK) begin
		if (CE && WR.we) begin
			mem[WR.addr] <= WR.data;
		end
	end

	// Read register, cleared by reset
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			rdata_q <= '0;
		end else if (CE) begin
			rdata_q <= mem[RADDR];
		end
	end

	assign RDATA = rdata_q;

endmodule : mtcmp_thr_mem

`default_nettype wire

// file: hw/mtcmp_top.sv
// Multi-level threshold comparator with Avalon-MM register access.
//
// How it works
// - Each set holds up to four thresholds
// - Sixteen sets stored, any one active
// - Below first threshold gives output 0
// - Between thresholds k and k+1 gives k
// - At or above fourth threshold gives 4
// - Positioning mode evaluates a single level only
// - Open-collector and relay groups show same judgment
// - Four select pins weighted bit 0 to 3
// - Select pins active low, all high is 00
// - Undriven select pins fall back to set 00
// - Latch pin sits beside the select pins
// - Input change acts no sooner than 3 ms
// - Debounce option adds 350 us, else 3 us
// - Asserted latch freezes the current judgment
// - Thresholds within a set strictly ascending
`default_nettype none

module mtcmp_top
	import mtcmp_pkg::*;
#(
	// Cycles to internal operation; shorten only in simulation
	parameter int INT_DELAY_CYC_P = INT_DELAY_CYC
) (
	// Clock, reset and freeze
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CE,
	// Measured value from the counter, same clock
	input wire logic [DATA_W-1:0] MEAS_VALUE,
	// Isolated external inputs, low = active
	input wire logic SET_SELECT_IN_B0_N,
	input wire logic SET_SELECT_IN_B1_N,
	input wire logic SET_SELECT_IN_B2_N,
	input wire logic SET_SELECT_IN_B3_N,
	input wire logic LATCH_IN_N,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [BE_W-1:0] AVS_BYTEENABLE,
	output logic [DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Open-collector judgment drivers, high = on
	output logic JUDGE_OC_OUT0,
	output logic JUDGE_OC_OUT1,
	output logic JUDGE_OC_OUT2,
	output logic JUDGE_OC_OUT3,
	output logic JUDGE_OC_OUT4,
	// Relay judgment drivers, high = on
	output logic JUDGE_RELAY_OUT0,
	output logic JUDGE_RELAY_OUT1,
	output logic JUDGE_RELAY_OUT2,
	output logic JUDGE_RELAY_OUT3,
	output logic JUDGE_RELAY_OUT4
);

	// Replace the enabled byte lanes of an old word
	function automatic mtcmp_word_t be_merge(input mtcmp_word_t old_w,
		input mtcmp_word_t new_w, input logic [BE_W-1:0] be);
		mtcmp_word_t r;
		r = old_w;
		for (int b = 0; b < BE_W; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// Signed at-or-above test used by both judgment and write check
	function automatic logic at_or_above(input mtcmp_word_t v,
		input mtcmp_word_t t);
		return $signed(v) >= $signed(t);
	endfunction : at_or_above

	mtcmp_state_s q; // Registered state
	mtcmp_state_s d; // Next state
	mtcmp_avs_req_s req; // Bus request as held by the master
	mtcmp_memwr_s mem_wr; // Threshold memory write
	logic [SET_W-1:0] mem_raddr; // Threshold memory read set
	mtcmp_set_t mem_rdata; // Threshold set read back
	logic [IN_N-1:0] pin_raw; // Raw pins, latch on top
	logic [CNT_W-1:0] filt_lim; // Stable cycles before acceptance
	logic [SET_W-1:0] sel_set; // Set chosen for judgment
	logic latch_on; // Accepted latch level
	logic bus_idle; // No request pending
	logic [SET_W-1:0] req_set; // Set field of the bus address
	logic [LVL_W-1:0] req_lvl; // Threshold field of the bus address
	logic req_thr; // Address falls in the threshold block
	logic [NLEV_W-1:0] nlev_use; // Levels that take part in judging
	logic [BAND_W-1:0] band; // Band the measured value lies in
	mtcmp_word_t thr_new; // Threshold after byte merge
	mtcmp_word_t ctrl_word; // Control register image
	mtcmp_word_t stat_word; // Status register image
	logic thr_ok; // Threshold write keeps the set ascending

	// Bundle the bus pins
	assign req.addr = AVS_ADDRESS;
	assign req.rd = AVS_READ;
	assign req.wr = AVS_WRITE;
	assign req.wdata = AVS_WRITEDATA;
	assign req.be = AVS_BYTEENABLE;

	// Bit 0 to bit 3 weighting of the select pins
	assign pin_raw = {LATCH_IN_N, SET_SELECT_IN_B3_N, SET_SELECT_IN_B2_N,
		SET_SELECT_IN_B1_N, SET_SELECT_IN_B0_N};

	// Memory reads the active set unless a bus request owns it
	assign bus_idle = (q.bstate == MTCMP_IDLE) && !(req.rd || req.wr);
	assign req_set = req.addr[ADR_SET_LSB +: SET_W];
	assign req_lvl = req.addr[ADR_LVL_LSB +: LVL_W];
	assign req_thr = (req.addr <= ADR_THR_LAST);
	assign mem_raddr = bus_idle ? sel_set : req_set;

	mtcmp_thr_mem u_mem (
		.CLOCK(CLOCK),
		.RESET(RESET),
		.CE(CE),
		.WR(mem_wr),
		.RADDR(mem_raddr),
		.RDATA(mem_rdata)
	);

	// Next-state logic
	always_comb begin
		d = q;
		mem_wr = '0;
		filt_lim = '0;
		sel_set = '0;
		latch_on = 1'b0;
		nlev_use = '0;
		band = '0;
		thr_new = WORD_ZERO;
		thr_ok = 1'b0;
		ctrl_word = WORD_ZERO;
		stat_word = WORD_ZERO;

		// Two-stage synchroniser; only stage two feeds the filter
		d.sync1 = pin_raw;
		d.sync2 = q.sync1;

		// Photocoupler delay plus the least delay to internal use
		if (q.deb_on) begin
			filt_lim = CNT_W'(INT_DELAY_CYC_P + DEB_DELAY_CYC);
		end else begin
			filt_lim = CNT_W'(INT_DELAY_CYC_P + FAST_DELAY_CYC);
		end

		// Any change restarts the count; glitches never reach use
		if (q.sync2 != q.samp) begin
			d.samp = q.sync2;
			d.cnt = '0;
		end else if (q.cnt < filt_lim) begin
			d.cnt = q.cnt + 1'b1;
		end else begin
			d.acc = q.samp;
		end

		// Low pin counts as one; idle high pins give set 00
		if (q.sw_sel) begin
			sel_set = q.sw_set;
		end else begin
			sel_set = ~q.acc[SET_W-1:0];
		end
		latch_on = ~q.acc[IN_LATCH_BIT];

		// Positioning mode judges against the first level only
		nlev_use = q.nlev[q.rd_set];
		if (q.mode_pos && (nlev_use > NLEV_W'(1))) begin
			nlev_use = NLEV_W'(1);
		end

		// Count thresholds reached; ascending order makes it the band
		for (int k = 0; k < LVL_N; k++) begin
			if ((NLEV_W'(k) < nlev_use)
				&& at_or_above(MEAS_VALUE, mem_rdata[k])) begin
				band = BAND_W'(k + 1);
			end
		end

		// Read data of the active set arrive one cycle after the address
		d.rd_judge = bus_idle;
		d.rd_set = sel_set;
		d.latched = latch_on;
		if (q.rd_judge && !latch_on) begin
			d.judge = BAND_N'(1) << band;
		end // Held while latched

		// Register images
		ctrl_word[CTRL_MODE_BIT] = q.mode_pos;
		ctrl_word[CTRL_DEB_BIT] = q.deb_on;
		ctrl_word[CTRL_SWSEL_BIT] = q.sw_sel;
		ctrl_word[CTRL_SWSET_LSB +: SET_W] = q.sw_set;
		stat_word[ST_JUDGE_LSB +: BAND_N] = q.judge;
		stat_word[ST_SET_LSB +: SET_W] = sel_set;
		stat_word[ST_LATCH_BIT] = q.latched;
		stat_word[ST_REJ_BIT] = q.wr_rej;
		stat_word[ST_NLEV_LSB +: NLEV_W] = q.nlev[sel_set];

		// A write may replace a stored level or add the next one, and must exceed its predecessor
		thr_new = be_merge(mem_rdata[req_lvl], req.wdata, req.be);
		if (NLEV_W'(req_lvl) > q.nlev[req_set]) begin
			thr_ok = 1'b0;
		end else if (req_lvl == '0) begin
			thr_ok = 1'b1;
		end else begin
			thr_ok = !at_or_above(mem_rdata[req_lvl - 1'b1], thr_new);
		end

		// Avalon slave: take, evaluate with memory data, answer
		case (q.bstate)
			MTCMP_IDLE: begin
				if (req.rd || req.wr) begin
					d.bstate = MTCMP_EVAL;
				end
			end
			MTCMP_EVAL: begin
				d.bstate = MTCMP_ACK;
				d.waitreq = 1'b0;
				d.rdata = WORD_ZERO;
				if (req.wr) begin
					if (req_thr) begin
						// Accepted value drops every later level
						d.wr_rej = !thr_ok;
						if (thr_ok) begin
							mem_wr.we = 1'b1;
							mem_wr.addr = req_set;
							mem_wr.data = mem_rdata;
							mem_wr.data[req_lvl] = thr_new;
							d.nlev[req_set] = NLEV_W'(req_lvl) + 1'b1;
						end
					end else if (req.addr == ADR_CTRL) begin
						ctrl_word = be_merge(ctrl_word, req.wdata, req.be);
						d.mode_pos = ctrl_word[CTRL_MODE_BIT];
						d.deb_on = ctrl_word[CTRL_DEB_BIT];
						d.sw_sel = ctrl_word[CTRL_SWSEL_BIT];
						d.sw_set = ctrl_word[CTRL_SWSET_LSB +: SET_W];
					end
				end else if (req_thr) begin
					d.rdata = mem_rdata[req_lvl];
				end else if (req.addr == ADR_CTRL) begin
					d.rdata = ctrl_word;
				end else if (req.addr == ADR_STATUS) begin
					d.rdata = stat_word;
				end else if (req.addr == ADR_MEAS) begin
					d.rdata = MEAS_VALUE;
				end // Unmapped: reads zero, writes ignored
			end
			MTCMP_ACK: begin
				// Master releases on this edge; raise the wait again
				d.bstate = MTCMP_IDLE;
				d.waitreq = 1'b1;
			end
			default: begin
				d.bstate = MTCMP_IDLE;
				d.waitreq = 1'b1;
			end
		endcase
	end

	// State register; low clock enable freezes everything
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			q <= '0;
			q.sync1 <= IN_IDLE;
			q.sync2 <= IN_IDLE;
			q.samp <= IN_IDLE;
			q.acc <= IN_IDLE;
			q.mode_pos <= CTRL_RESET[CTRL_MODE_BIT];
			q.deb_on <= CTRL_RESET[CTRL_DEB_BIT];
			q.sw_sel <= CTRL_RESET[CTRL_SWSEL_BIT];
			q.sw_set <= CTRL_RESET[CTRL_SWSET_LSB +: SET_W];
			q.bstate <= MTCMP_IDLE;
			q.waitreq <= 1'b1;
			q.judge <= JUDGE_RESET;
		end else if (CE) begin
			q <= d;
		end
	end

	// Both driver groups come from the same judgment flops
	assign JUDGE_OC_OUT0 = q.judge[0];
	assign JUDGE_OC_OUT1 = q.judge[1];
	assign JUDGE_OC_OUT2 = q.judge[2];
	assign JUDGE_OC_OUT3 = q.judge[3];
	assign JUDGE_OC_OUT4 = q.judge[4];
	assign JUDGE_RELAY_OUT0 = q.judge[0];
	assign JUDGE_RELAY_OUT1 = q.judge[1];
	assign JUDGE_RELAY_OUT2 = q.judge[2];
	assign JUDGE_RELAY_OUT3 = q.judge[3];
	assign JUDGE_RELAY_OUT4 = q.judge[4];
	assign AVS_READDATA = q.rdata;
	assign AVS_WAITREQUEST = q.waitreq;

endmodule : mtcmp_top

`default_nettype wire

// file: bench/mtcmp_checker.sv
// Checker: judgment, pin and bus relations at the comparator top.
`default_nettype none

module mtcmp_checker
	import mtcmp_pkg::*;
#(
	parameter int INT_DELAY_CYC_P = INT_DELAY_CYC
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Causes
	input wire logic [DATA_W-1:0] MEAS_VALUE,
	input wire logic SET_SELECT_IN_B0_N,
	input wire logic SET_SELECT_IN_B1_N,
	input wire logic SET_SELECT_IN_B2_N,
	input wire logic SET_SELECT_IN_B3_N,
	input wire logic LATCH_IN_N,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	// Bus answer
	input wire logic [DATA_W-1:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Judgment drivers
	input wire logic JUDGE_OC_OUT0,
	input wire logic JUDGE_OC_OUT1,
	input wire logic JUDGE_OC_OUT2,
	input wire logic JUDGE_OC_OUT3,
	input wire logic JUDGE_OC_OUT4,
	input wire logic JUDGE_RELAY_OUT0,
	input wire logic JUDGE_RELAY_OUT1,
	input wire logic JUDGE_RELAY_OUT2,
	input wire logic JUDGE_RELAY_OUT3,
	input wire logic JUDGE_RELAY_OUT4
);
	timeunit 1ns;
	timeprecision 1ns;

	// Longest filter (debounce on) plus pipeline margin
	localparam int LATCH_LIM = INT_DELAY_CYC_P + 3540;
	logic [BAND_N-1:0] oc, ry; // Both driver groups
	logic [IN_N-1:0] pins, pins_q; // Pins now and one edge ago
	logic [DATA_W-1:0] meas_q; // Value one edge ago
	logic [15:0] age_q, quiet_q, low_q; // Saturating cycle counts

	assign oc = {JUDGE_OC_OUT4, JUDGE_OC_OUT3, JUDGE_OC_OUT2,
		JUDGE_OC_OUT1, JUDGE_OC_OUT0};
	assign ry = {JUDGE_RELAY_OUT4, JUDGE_RELAY_OUT3, JUDGE_RELAY_OUT2,
		JUDGE_RELAY_OUT1, JUDGE_RELAY_OUT0};
	assign pins = {LATCH_IN_N, SET_SELECT_IN_B3_N, SET_SELECT_IN_B2_N,
		SET_SELECT_IN_B1_N, SET_SELECT_IN_B0_N};

	// Ages: since a pin moved, since bus and value went quiet, latch low
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			pins_q <= IN_IDLE;
			meas_q <= WORD_ZERO;
			age_q <= 16'h0000;
			quiet_q <= 16'h0000;
			low_q <= 16'h0000;
		end else begin
			pins_q <= pins;
			meas_q <= MEAS_VALUE;
			age_q <= (pins != pins_q) ? 16'h0000 : age_q + 16'(~&age_q);
			quiet_q <= (AVS_READ || AVS_WRITE || MEAS_VALUE != meas_q) ?
				16'h0000 : quiet_q + 16'(~&quiet_q);
			low_q <= LATCH_IN_N ? 16'h0000 : low_q + 16'(~&low_q);
		end
	end

	default clocking dcb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// Request seen high, still waiting next edge, answered the one after
	sequence s_answer;
		AVS_WAITREQUEST ##1 AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence

	a_groups_equal: assert property (oc == ry)
		else $error("driver groups differ");
	a_one_band: assert property ($onehot(oc))
		else $error("judgment not exactly one output");
	a_reset_band0: assert property ($fell(RESET) |->
		oc == JUDGE_RESET && AVS_WAITREQUEST)
		else $error("state after reset wrong");
	a_answer_time: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_answer)
		else $error("bus answer not at third edge");
	a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_rdata_holds: assert property (AVS_WAITREQUEST &&
		$past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
		else $error("read data moved between answers");
	a_no_early: assert property (age_q >= 4 && age_q <=
		INT_DELAY_CYC_P && quiet_q >= 6 |-> $stable(oc))
		else $error("pin change acted too early");
	a_latch_hold: assert property (low_q > LATCH_LIM |->
		$stable(oc))
		else $error("judgment moved while latched");
endmodule : mtcmp_checker

bind mtcmp_top mtcmp_checker #(.INT_DELAY_CYC_P(INT_DELAY_CYC_P)) u_chk (
	.CLOCK(CLOCK), .RESET(RESET), .MEAS_VALUE(MEAS_VALUE),
	.SET_SELECT_IN_B0_N(SET_SELECT_IN_B0_N),
	.SET_SELECT_IN_B1_N(SET_SELECT_IN_B1_N),
	.SET_SELECT_IN_B2_N(SET_SELECT_IN_B2_N),
	.SET_SELECT_IN_B3_N(SET_SELECT_IN_B3_N), .LATCH_IN_N(LATCH_IN_N),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.JUDGE_OC_OUT0(JUDGE_OC_OUT0), .JUDGE_OC_OUT1(JUDGE_OC_OUT1),
	.JUDGE_OC_OUT2(JUDGE_OC_OUT2), .JUDGE_OC_OUT3(JUDGE_OC_OUT3),
	.JUDGE_OC_OUT4(JUDGE_OC_OUT4), .JUDGE_RELAY_OUT0(JUDGE_RELAY_OUT0),
	.JUDGE_RELAY_OUT1(JUDGE_RELAY_OUT1), .JUDGE_RELAY_OUT2(JUDGE_RELAY_OUT2),
	.JUDGE_RELAY_OUT3(JUDGE_RELAY_OUT3), .JUDGE_RELAY_OUT4(JUDGE_RELAY_OUT4));

`default_nettype wire

// file: bench/mtcmp_ext_ctl.sv
// External controller model driving the set select and latch pins.
`default_nettype none

module mtcmp_ext_ctl
	import mtcmp_pkg::*;
(
	// Clock and commands from the bench
	input wire logic clk,
	input wire logic drive_en,
	input wire logic [SET_W-1:0] set_num,
	input wire logic latch_on,
	// Isolated pins, low = active
	output logic [SET_W-1:0] sel_n,
	output logic latch_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pins move just after an edge; released pins rest at the pull-up
	always_ff @(posedge clk) begin
		sel_n <= drive_en ? ~set_num : IN_IDLE[SET_W-1:0];
		latch_n <= ~latch_on;
	end
endmodule : mtcmp_ext_ctl

`default_nettype wire

// file: bench/mtcmp_tb_top.sv
// Self-checking bench: bus tasks, pin model and judgment tests.
`default_nettype none

module mtcmp_tb_top
	import mtcmp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int DLY = 20; // Shortened time to internal operation
	localparam int SETTLE = DLY + 40; // Sync, filter and outputs
	logic clk, rst, rd, wr, wreq, drv, latch_on, latch_n;
	logic ce; // Clock enable under test
	logic [BE_W-1:0] be; // Byte lanes of the next request
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] meas, wdata, rdata, q;
	logic [SET_W-1:0] set_num, sel_n;
	logic [BAND_N-1:0] oc, ry;
	int n_mismatch, num_checks;
	logic [DATA_W-1:0] mv[8] = '{32'hFFFF_FFFB, 32'h64, 32'hC7, 32'hC8,
		32'h12C, 32'h18F, 32'h190, 32'h3E8}; // Sweep values
	int bv[8] = '{0, 1, 1, 2, 3, 3, 4, 4}; // Bands they fall in

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	mtcmp_ext_ctl u_ext (.clk(clk), .drive_en(drv), .set_num(set_num),
		.latch_on(latch_on), .sel_n(sel_n), .latch_n(latch_n));

	mtcmp_top #(.INT_DELAY_CYC_P(DLY)) uut (.CLOCK(clk), .RESET(rst),
		.CE(ce), .MEAS_VALUE(meas), .SET_SELECT_IN_B0_N(sel_n[0]),
		.SET_SELECT_IN_B1_N(sel_n[1]), .SET_SELECT_IN_B2_N(sel_n[2]),
		.SET_SELECT_IN_B3_N(sel_n[3]), .LATCH_IN_N(latch_n),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .JUDGE_OC_OUT0(oc[0]), .JUDGE_OC_OUT1(oc[1]),
		.JUDGE_OC_OUT2(oc[2]), .JUDGE_OC_OUT3(oc[3]), .JUDGE_OC_OUT4(oc[4]),
		.JUDGE_RELAY_OUT0(ry[0]), .JUDGE_RELAY_OUT1(ry[1]),
		.JUDGE_RELAY_OUT2(ry[2]), .JUDGE_RELAY_OUT3(ry[3]),
		.JUDGE_RELAY_OUT4(ry[4]));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [DATA_W-1:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Both groups must show the one expected band
	task automatic chk_band(input int b);
		chk("oc group", 32'h1 << b, {27'h0, oc});
		chk("relay group", 32'h1 << b, {27'h0, ry});
	endtask : chk_band

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int i;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 50) begin
			chk("waitrequest", 32'h0, 32'h1);
			give_verdict();
		end
	endtask : bus

	// Bounded wait for a band, then compare it
	task automatic wait_band(input int b, input int lim);
		int i;
		for (i = 0; i < lim && oc !== BAND_N'(1 << b); i++) begin
			@(posedge clk);
		end
		chk_band(b);
		if (i == lim) give_verdict();
	endtask : wait_band

	task automatic done(input string t);
		$display("test %s over, mismatches %0d", t, n_mismatch);
	endtask : done

	initial begin
		rst = 1'b1;
		{rd, wr, drv, latch_on} = 4'h0;
		ce = 1'b1;
		be = 4'hF;
		{addr, wdata, meas, set_num} = '0;
		n_mismatch = 0;
		num_checks = 0;
		tick(20);
		rst <= 1'b0;
		tick(1);
		chk_band(0);
		bus(1'b0, ADR_CTRL, WORD_ZERO);
		chk("ctrl", CTRL_RESET, q);
		done("reset");
		// Set 0 gets four thresholds; sweep each band edge, signed too
		for (int i = 0; i < LVL_N; i++) begin
			bus(1'b1, ADDR_W'(i), 32'(100 * (i + 1)));
		end
		for (int i = 0; i < 8; i++) begin
			meas <= mv[i];
			wait_band(bv[i], 10);
		end
		// Set 1: falling entry and a level past the count are refused
		bus(1'b1, 7'h04, 32'h0000_01F4);
		bus(1'b1, 7'h05, 32'h0000_0190);
		bus(1'b0, ADR_STATUS, WORD_ZERO);
		chk("refused", 32'h1, 32'(q[ST_REJ_BIT]));
		bus(1'b1, 7'h07, 32'h0000_0FFF);
		bus(1'b0, ADR_STATUS, WORD_ZERO);
		chk("refused", 32'h1, 32'(q[ST_REJ_BIT]));
		bus(1'b1, 7'h05, 32'h0000_0258);
		bus(1'b0, ADR_STATUS, WORD_ZERO);
		chk("refused", 32'h0, 32'(q[ST_REJ_BIT]));
		bus(1'b1, 7'h3C, 32'h0000_03E8);
		// Positioning mode weighs the first threshold only
		meas <= 32'h0000_015E;
		wait_band(3, 10);
		bus(1'b1, ADR_CTRL, 32'h1);
		wait_band(1, 10);
		bus(1'b1, ADR_CTRL, WORD_ZERO);
		wait_band(3, 10);
		done("bands");
		// Every pin code picks its own set; released pins give set 0
		for (int s = 0; s < SET_N; s++) begin
			drv <= 1'b1;
			set_num <= SET_W'(s);
			tick(SETTLE);
			bus(1'b0, ADR_STATUS, WORD_ZERO);
			chk("set", 32'(s), 32'(q[ST_SET_LSB +: SET_W]));
		end
		wait_band(0, 10);
		drv <= 1'b0;
		tick(SETTLE);
		bus(1'b0, ADR_STATUS, WORD_ZERO);
		chk("set", 32'h0, 32'(q[ST_SET_LSB +: SET_W]));
		wait_band(3, 10);
		done("select");
		// Filter: nothing moves early, debounce stretches the wait
		meas <= 32'h0000_0226;
		wait_band(4, 10);
		drv <= 1'b1;
		set_num <= 4'h1;
		tick(DLY);
		chk_band(4);
		wait_band(1, SETTLE);
		bus(1'b1, ADR_CTRL, 32'h2);
		set_num <= 4'h0;
		tick(SETTLE);
		chk_band(1);
		wait_band(4, 3600);
		bus(1'b1, ADR_CTRL, WORD_ZERO);
		done("filter");
		// Latch held low freezes the judgment; release tracks again
		meas <= 32'h0000_0096;
		wait_band(1, 10);
		latch_on <= 1'b1;
		tick(SETTLE);
		meas <= 32'h0000_015E;
		tick(3600);
		chk_band(1);
		latch_on <= 1'b0;
		wait_band(3, SETTLE);
		done("latch");
		// Unmapped place reads zero; value and threshold read back
		bus(1'b1, 7'h50, 32'hFFFF_FFFF);
		bus(1'b0, 7'h50, WORD_ZERO);
		chk("unmapped", WORD_ZERO, q);
		bus(1'b0, ADR_MEAS, WORD_ZERO);
		chk("meas", 32'h0000_015E, q);
		bus(1'b0, 7'h01, WORD_ZERO);
		chk("threshold", 32'h0000_00C8, q);
		// Only the enabled lane replaces part of the stored word
		be <= 4'h1;
		bus(1'b1, 7'h3C, 32'hFFFF_FFF0);
		be <= 4'hF;
		bus(1'b0, 7'h3C, WORD_ZERO);
		chk("lane merge", 32'h0000_03F0, q);
		// Software select overrides the pins
		bus(1'b1, ADR_CTRL, 32'h14);
		bus(1'b0, ADR_CTRL, WORD_ZERO);
		chk("ctrl", 32'h0000_0014, q);
		bus(1'b0, ADR_STATUS, WORD_ZERO);
		chk("set", 32'h1, 32'(q[ST_SET_LSB +: SET_W]));
		wait_band(0, 10);
		bus(1'b1, ADR_CTRL, WORD_ZERO);
		wait_band(3, 10);
		// Low clock enable freezes the judgment until it returns
		ce <= 1'b0;
		meas <= 32'h0000_0096;
		tick(10);
		chk_band(3);
		ce <= 1'b1;
		wait_band(1, 10);
		done("bus");
		give_verdict();
	end
endmodule : mtcmp_tb_top

`default_nettype wire
